// ---- design/dclr_top.sv ----
// Top of the DAC clear control block: register file, pin sampling, outputs.
// Assumes alarm flags come from logic on sys_clk_in and the clear pin is
// asynchronous to it; registers are reached over a plain strobe port.
`timescale 1ns/1ps
`include "dclr_consts.svh"

// ****************************************************************
// Module declaration
// ****************************************************************

// Contract
// R01 - Source select register decides which alarms clear DACs, in any mode.
// R02 - Bits 14..11 pick inputs 0..3; clear needs enable and flag.
// R03 - An unselected alarm is still flagged but clears no DAC.
// R04 - Bits 10 and 9 pick local low and high alarms, per-DAC gated.
// R05 - Bits 8..5 pick remote one and two low and high alarms.
// R06 - Bits 4 and 3 pick remote one and two fail alarms.
// R07 - Bit 2 picks thermal alarm; it resets to one, others to zero.
// R08 - Thermal clear ignores per-DAC enables and clears all DACs.
// R09 - Source bits 15, 1, 0 read zero and ignore writes.
// R10 - Auto-clear bits 14..3 map DAC11..0; one allows alarm clearing.
// R11 - Software clear bits 14..3 force DACs clear while one.
// R12 - Pin zero enable bits let the low pin clear those DACs.
// R13 - Per-DAC registers read zero in bit 15 and bits 2..0.
// R14 - Clears act at once regardless of the synchronous load option.
// R15 - A DAC stays clear while any of its clear requests is active.
module dclr_top
    import dclr_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic                   sys_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   ce_in,
    // Register port.
    input  wire logic [`DCLR_ADDR_W-1:0] reg_addr_in,
    input  wire logic [15:0]            reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic      [15:0]            reg_rdata_out,
    // Alarm status flags, same clock domain.
    input  wire logic [3:0]             input_alarm_flag_in,
    input  wire logic                   local_temp_low_flag_in,
    input  wire logic                   local_temp_high_flag_in,
    input  wire logic                   remote1_low_flag_in,
    input  wire logic                   remote1_high_flag_in,
    input  wire logic                   remote2_low_flag_in,
    input  wire logic                   remote2_high_flag_in,
    input  wire logic                   remote1_fail_flag_in,
    input  wire logic                   remote2_fail_flag_in,
    input  wire logic                   overtemp_alarm_flag_in,
    // Hardware clear pin, active low, asynchronous.
    input  wire logic                   hw_clear_pin_zero_n_in,
    // Clear state per DAC and the causes behind it.
    output logic      [11:0]            dac_clear_out,
    output logic      [3:0]             clear_cause_out
);

    // ****************************************************************
    // Declarations
    // ****************************************************************

    dclr_word_t    source_sel;
    dclr_dac_vec_t auto_clear_dac_bit;
    dclr_dac_vec_t software_clear_dac_bit;
    dclr_dac_vec_t pin0_clear_dac_bit;
    logic          pin0_meta_n;
    logic          pin0_sync_n;
    logic          wr_source;
    logic          wr_auto_en;
    logic          wr_sw_clear;
    logic          wr_pin0_en;
    dclr_word_t    next_rdata;
    logic [11:0]   alarm_vec;

    dclr_clr_if clr_bus ();

    // ****************************************************************
    // Write decode
    // ****************************************************************

    // One decoded strobe per register; unmapped writes fall through.
    assign wr_source   = reg_wr_in && (reg_addr_in == `DCLR_OFS_SOURCE);
    assign wr_auto_en  = reg_wr_in && (reg_addr_in == `DCLR_OFS_AUTO_EN);
    assign wr_sw_clear = reg_wr_in && (reg_addr_in == `DCLR_OFS_SW_CLEAR);
    assign wr_pin0_en  = reg_wr_in && (reg_addr_in == `DCLR_OFS_PIN0_EN);

    // ****************************************************************
    // Alarm source selection register
    // ****************************************************************

    // Reserved bits are masked at write so they can never hold a one.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            source_sel <= `DCLR_RST_SOURCE; // R07
        end else if (ce_in && wr_source) begin
            source_sel <= reg_wdata_in & `DCLR_MASK_SOURCE; // R01 R09
        end
    end

    // ****************************************************************
    // Auto-clear enable register
    // ****************************************************************

    // Only the twelve DAC bits are stored; the rest is rebuilt as zero.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            auto_clear_dac_bit <= dclr_dac_field(`DCLR_RST_AUTO_EN);
        end else if (ce_in && wr_auto_en) begin
            auto_clear_dac_bit <= dclr_dac_field(reg_wdata_in); // R10 R13
        end
    end

    // ****************************************************************
    // Software clear register
    // ****************************************************************

    // Writing zero lifts the software clear; other sources may still hold.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            software_clear_dac_bit <= dclr_dac_field(`DCLR_RST_SW_CLEAR);
        end else if (ce_in && wr_sw_clear) begin
            software_clear_dac_bit <= dclr_dac_field(reg_wdata_in); // R11 R13
        end
    end

    // ****************************************************************
    // Pin zero clear enable register
    // ****************************************************************

    // Enables decide which DACs follow the pin; the pin itself is sampled.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin0_clear_dac_bit <= dclr_dac_field(`DCLR_RST_PIN0_EN);
        end else if (ce_in && wr_pin0_en) begin
            pin0_clear_dac_bit <= dclr_dac_field(reg_wdata_in); // R12 R13
        end
    end

    // ****************************************************************
    // Clear pin synchroniser
    // ****************************************************************

    // Two flops against metastability; the pin idles high, so reset to one.
    // The price is two cycles of latency; the pin reaches the clear three edges later.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin0_meta_n <= 1'b1;
            pin0_sync_n <= 1'b1;
        end else if (ce_in) begin
            pin0_meta_n <= hw_clear_pin_zero_n_in;
            pin0_sync_n <= pin0_meta_n;
        end
    end

    // ****************************************************************
    // Combiner hookup
    // ****************************************************************

    // Alarm flags ordered to line up with source bits 14 down to 3.
    // The remote one fail source follows the remote one fail flag.
    assign alarm_vec = {input_alarm_flag_in[0],
                        input_alarm_flag_in[1],
                        input_alarm_flag_in[2],
                        input_alarm_flag_in[3],
                        local_temp_low_flag_in,
                        local_temp_high_flag_in,
                        remote1_low_flag_in,
                        remote1_high_flag_in,
                        remote2_low_flag_in,
                        remote2_high_flag_in,
                        remote1_fail_flag_in,
                        remote2_fail_flag_in}; // R02 R04 R05 R06

    // Register values and live conditions go to the combiner.
    assign clr_bus.source_sel = source_sel;
    assign clr_bus.auto_en    = auto_clear_dac_bit;
    assign clr_bus.sw_clear   = software_clear_dac_bit;
    assign clr_bus.pin0_en    = pin0_clear_dac_bit;
    assign clr_bus.alarm_vec  = alarm_vec;
    assign clr_bus.overtemp   = overtemp_alarm_flag_in;
    assign clr_bus.pin0_low   = ~pin0_sync_n; // R12

    dclr_combine u_combine (
        .bus (clr_bus.comb)
    );

    // ****************************************************************
    // Clear outputs
    // ****************************************************************

    // Outputs come straight from flops, one cycle after the combined request.
    // No load-mode input exists here, so nothing can delay the clear.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            dac_clear_out <= 12'h000;
        end else if (ce_in) begin
            dac_clear_out <= clr_bus.clear_req; // R14 R15
        end
    end

    // Cause summary for software and for the surrounding logic.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            clear_cause_out <= 4'h0;
        end else if (ce_in) begin
            clear_cause_out <= clr_bus.cause;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************

    // Read mux; unmapped addresses answer zero rather than stale data.
    always_comb begin
        next_rdata = 16'h0000;
        unique case (reg_addr_in)
            `DCLR_OFS_SOURCE: begin
                next_rdata = source_sel & `DCLR_MASK_SOURCE; // R09
            end
            `DCLR_OFS_AUTO_EN: begin
                next_rdata = dclr_dac_word(auto_clear_dac_bit); // R13
            end
            `DCLR_OFS_SW_CLEAR: begin
                next_rdata = dclr_dac_word(software_clear_dac_bit); // R13
            end
            `DCLR_OFS_PIN0_EN: begin
                next_rdata = dclr_dac_word(pin0_clear_dac_bit); // R13
            end
            `DCLR_OFS_CLR_STATE: begin
                next_rdata = dclr_dac_word(dac_clear_out);
            end
            `DCLR_OFS_CLR_CAUSE: begin
                next_rdata = {12'h000, clear_cause_out};
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // Read data stands for exactly the cycle after the strobe.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (ce_in) begin
            if (reg_rd_in) begin
                reg_rdata_out <= next_rdata;
            end else begin
                reg_rdata_out <= 16'h0000;
            end
        end
    end

endmodule : dclr_top

// ---- design/dclr_consts.svh ----
// Constants of the DAC clear control block: offsets, fields, resets, masks.
// Assumes it is included by its bare name from the package and the modules.
`ifndef DCLR_CONSTS_SVH
`define DCLR_CONSTS_SVH

// Register offsets on the plain register port.
`define DCLR_ADDR_W          8
`define DCLR_OFS_SOURCE      8'h53
`define DCLR_OFS_AUTO_EN     8'h54
`define DCLR_OFS_SW_CLEAR    8'h55
`define DCLR_OFS_PIN0_EN     8'h56
`define DCLR_OFS_CLR_STATE   8'h70
`define DCLR_OFS_CLR_CAUSE   8'h71

// Reset values.
`define DCLR_RST_SOURCE      16'h0004
`define DCLR_RST_AUTO_EN     16'h0000
`define DCLR_RST_SW_CLEAR    16'h0000
`define DCLR_RST_PIN0_EN     16'h0000

// Writable bit masks; every other bit reads as zero.
`define DCLR_MASK_SOURCE     16'h7FFC
`define DCLR_MASK_DAC        16'h7FF8

// Field positions.
`define DCLR_DAC_LSB         3
`define DCLR_DAC_MSB         14
`define DCLR_ALARM_LSB       3
`define DCLR_ALARM_MSB       14
`define DCLR_THERMAL_BIT     2

// Clear cause bit positions.
`define DCLR_CAUSE_SW        0
`define DCLR_CAUSE_PIN       1
`define DCLR_CAUSE_ALARM     2
`define DCLR_CAUSE_THERMAL   3

`endif

// ---- design/dclr_pkg.sv ----
// Types and field helpers of the DAC clear control block.
// Assumes the constants header sits on the include path.
`include "dclr_consts.svh"

package dclr_pkg;

    typedef logic [15:0] dclr_word_t;
    typedef logic [11:0] dclr_dac_vec_t;
    typedef logic [3:0]  dclr_cause_t;

    // Pulls the twelve per-DAC bits out of a register word.
    function automatic dclr_dac_vec_t dclr_dac_field(input dclr_word_t word);
        dclr_dac_field = word[`DCLR_DAC_MSB:`DCLR_DAC_LSB];
    endfunction : dclr_dac_field

    // Places twelve per-DAC bits into a register word, other bits zero.
    function automatic dclr_word_t dclr_dac_word(input dclr_dac_vec_t vec);
        dclr_dac_word = {1'b0, vec, 3'h0};
    endfunction : dclr_dac_word

endpackage : dclr_pkg

// ---- design/dclr_clr_if.sv ----
// Carrier between the register side and the clear combiner.
// Assumes both ends run on the same clock; the carrier holds no state.
`timescale 1ns/1ps

interface dclr_clr_if;
    import dclr_pkg::*;

    dclr_word_t    source_sel;
    dclr_dac_vec_t auto_en;
    dclr_dac_vec_t sw_clear;
    dclr_dac_vec_t pin0_en;
    logic [11:0]   alarm_vec;
    logic          overtemp;
    logic          pin0_low;
    dclr_dac_vec_t clear_req;
    dclr_cause_t   cause;

    modport regs (
        output source_sel, auto_en, sw_clear, pin0_en,
        output alarm_vec, overtemp, pin0_low,
        input  clear_req, cause
    );

    modport comb (
        input  source_sel, auto_en, sw_clear, pin0_en,
        input  alarm_vec, overtemp, pin0_low,
        output clear_req, cause
    );
endinterface : dclr_clr_if

// ---- design/dclr_combine.sv ----
// Per-DAC clear request combiner, purely combinational.
// Assumes the alarm vector is ordered like source bits 14 down to 3.
`timescale 1ns/1ps
`include "dclr_consts.svh"

module dclr_combine
    import dclr_pkg::*;
(
    // Register values and conditions in, requests out.
    dclr_clr_if.comb bus
);

    logic          any_alarm;
    logic          thermal_all;
    dclr_dac_vec_t alarm_part;
    dclr_dac_vec_t pin_part;

    // An alarm only counts when its source bit selects it.
    assign any_alarm = |(bus.source_sel[`DCLR_ALARM_MSB:`DCLR_ALARM_LSB] & bus.alarm_vec); // R02 R04 R05 R06
    // Unselected alarms are still flagged upstream but never reach a DAC.
    assign alarm_part = any_alarm ? bus.auto_en : 12'h000; // R01 R03 R10
    // Thermal clear skips the per-DAC enables and hits every channel.
    assign thermal_all = bus.source_sel[`DCLR_THERMAL_BIT] & bus.overtemp; // R07 R08
    // The pin is active low and only reaches DACs whose enable is set.
    assign pin_part = bus.pin0_low ? bus.pin0_en : 12'h000; // R12

    // Any active source holds the DAC clear; load mode plays no part.
    assign bus.clear_req = bus.sw_clear | pin_part | alarm_part | {12{thermal_all}}; // R11 R14 R15

    // Summary of which sources are forcing something at the moment.
    assign bus.cause[`DCLR_CAUSE_SW]      = |bus.sw_clear;
    assign bus.cause[`DCLR_CAUSE_PIN]     = |pin_part;
    assign bus.cause[`DCLR_CAUSE_ALARM]   = |alarm_part;
    assign bus.cause[`DCLR_CAUSE_THERMAL] = thermal_all;

endmodule : dclr_combine

// ---- dv/dclr_top_properties.sv ----
// Concurrent checks on the ports of the DAC clear control top.
// Assumes every port is bound by name; registers are shadowed from the write port.
`timescale 1ns/1ps
module dclr_top_props
    import dclr_pkg::*;
(
    // Clock, reset and register port.
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    input wire logic        ce_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    // Alarm flags and the clear pin.
    input wire logic [3:0]  input_alarm_flag_in,
    input wire logic        local_temp_low_flag_in,
    input wire logic        local_temp_high_flag_in,
    input wire logic        remote1_low_flag_in,
    input wire logic        remote1_high_flag_in,
    input wire logic        remote2_low_flag_in,
    input wire logic        remote2_high_flag_in,
    input wire logic        remote1_fail_flag_in,
    input wire logic        remote2_fail_flag_in,
    input wire logic        overtemp_alarm_flag_in,
    input wire logic        hw_clear_pin_zero_n_in,
    // Clear state and causes.
    input wire logic [11:0] dac_clear_out,
    input wire logic [3:0]  clear_cause_out
);
    dclr_word_t  src, aen, swc, pen, rexp;
    logic        s1, s2, any_al, therm;
    logic [11:0] alv, exp_clr;

    // Alarm flags in source-bit order, 14 down to 3.
    assign alv = {input_alarm_flag_in[0], input_alarm_flag_in[1], input_alarm_flag_in[2],
        input_alarm_flag_in[3], local_temp_low_flag_in, local_temp_high_flag_in,
        remote1_low_flag_in, remote1_high_flag_in, remote2_low_flag_in,
        remote2_high_flag_in, remote1_fail_flag_in, remote2_fail_flag_in};
    assign any_al = |(src[14:3] & alv);
    assign therm = src[2] & overtemp_alarm_flag_in;
    assign exp_clr = swc[14:3] | (s2 ? 12'h000 : pen[14:3])
        | (any_al ? aen[14:3] : 12'h000) | {12{therm}};

    // Read data that a read of the current address should return.
    always_comb begin
        case (reg_addr_in)
            8'h53: rexp = src;
            8'h54: rexp = aen;
            8'h55: rexp = swc;
            8'h56: rexp = pen;
            8'h70: rexp = {1'b0, dac_clear_out, 3'h0};
            8'h71: rexp = {12'h000, clear_cause_out};
            default: rexp = 16'h0000;
        endcase
    end

    // Shadow registers keep only writable bits, as the block must.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            src <= 16'h0004;
            aen <= 16'h0000;
            swc <= 16'h0000;
            pen <= 16'h0000;
        end else if (reg_wr_in && ce_in) begin
            case (reg_addr_in)
                8'h53: src <= reg_wdata_in & 16'h7FFC;
                8'h54: aen <= reg_wdata_in & 16'h7FF8;
                8'h55: swc <= reg_wdata_in & 16'h7FF8;
                8'h56: pen <= reg_wdata_in & 16'h7FF8;
                default: ;
            endcase
        end
    end

    // Two flops on the asynchronous pin, matching the design latency.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
        end else if (ce_in) begin
            s1 <= hw_clear_pin_zero_n_in;
            s2 <= s1;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    AST_CLEAR_EQ: assert property (dac_clear_out == $past(exp_clr))
        else $error("Clear vector differs from combined requests.");
    AST_SW_CAUSE: assert property (clear_cause_out[0] == $past(|swc))
        else $error("Software cause bit wrong.");
    AST_THERM_CAUSE: assert property (clear_cause_out[3] == $past(therm))
        else $error("Thermal cause bit wrong.");
    AST_THERM_ALL: assert property (clear_cause_out[3] |-> dac_clear_out == 12'hFFF)
        else $error("Thermal clear left a DAC running.");
    AST_PIN_CAUSE: assert property (clear_cause_out[1] |-> $past(!s2))
        else $error("Pin cause without a low pin.");
    AST_ALARM_CAUSE: assert property (clear_cause_out[2] |-> $past(any_al))
        else $error("Alarm cause without a selected alarm.");
    AST_RD_DATA: assert property ($past(reg_rd_in) |-> reg_rdata_out == $past(rexp))
        else $error("Read data wrong.");
    AST_RD_DAC_RSV: assert property ($past(reg_rd_in) && $past(reg_addr_in) inside
        {8'h54, 8'h55, 8'h56} |-> (reg_rdata_out & 16'h8007) == 16'h0000)
        else $error("Reserved bits of a DAC register read nonzero.");

    COV_THERM: cover property (clear_cause_out[3]);
    COV_PIN: cover property (clear_cause_out[1]);
    COV_ALARM: cover property (clear_cause_out[2]);
endmodule : dclr_top_props

// ---- dv/test_dac_clear_control.sv ----
// Self-checking bench for the DAC clear control top.
// Assumes the checker module is compiled before this file.
`timescale 1ns/1ps
module test_dac_clear_control;
    import dclr_pkg::*;
    logic        sys_clk_in, rst_in, reg_wr_in, reg_rd_in, ovt, pin_n, rd_seen, ce;
    logic [7:0]  reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out, src, aen, swc, pen;
    logic [11:0] alv, dac_clear_out;
    logic [3:0]  clear_cause_out;
    logic [15:0] note_q[$];
    int          err_total, checked;

    dclr_top dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .input_alarm_flag_in({alv[8], alv[9], alv[10], alv[11]}),
        .local_temp_low_flag_in(alv[7]), .local_temp_high_flag_in(alv[6]),
        .remote1_low_flag_in(alv[5]), .remote1_high_flag_in(alv[4]),
        .remote2_low_flag_in(alv[3]), .remote2_high_flag_in(alv[2]),
        .remote1_fail_flag_in(alv[1]), .remote2_fail_flag_in(alv[0]),
        .overtemp_alarm_flag_in(ovt), .hw_clear_pin_zero_n_in(pin_n),
        .dac_clear_out(dac_clear_out), .clear_cause_out(clear_cause_out));

    // Expected clear vector and causes from the bench's own shadows.
    function automatic logic [15:0] exp_word(input logic cause);
        logic any_al;
        logic [11:0] c;
        any_al = |(src[14:3] & alv);
        c = swc[14:3] | (pin_n ? 12'h000 : pen[14:3]) | (any_al ? aen[14:3] : 12'h000);
        c = c | {12{src[2] & ovt}};
        if (cause) return {12'h000, src[2] & ovt, any_al & |aen, !pin_n & |pen, |swc};
        return {1'b0, c, 3'h0};
    endfunction : exp_word

    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : check

    // One bus cycle; exactly one strobe is set so operations may run back to back.
    task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        reg_wr_in <= w;
        reg_rd_in <= !w;
        reg_addr_in <= a;
        reg_wdata_in <= d;
    endtask : op

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        op(1'b1, a, d);
        if (a == 8'h53) src = d & 16'h7FFC;
        if (a == 8'h54) aen = d & 16'h7FF8;
        if (a == 8'h55) swc = d & 16'h7FF8;
        if (a == 8'h56) pen = d & 16'h7FF8;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        note_q.push_back(e);
        op(1'b0, a, 16'($urandom));
    endtask : rd

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge sys_clk_in);
            reg_wr_in <= 1'b0;
            reg_rd_in <= 1'b0;
        end
    endtask : idle

    // Waits past the three-edge pin latency, then reads state and cause.
    task automatic chk_state();
        idle(4);
        rd(8'h70, exp_word(1'b0));
        rd(8'h71, exp_word(1'b1));
    endtask : chk_state

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // Monitor: the read data stand only in the cycle after the strobe.
    always @(posedge sys_clk_in) begin
        if (rd_seen) check("reg_rdata_out", note_q.pop_front(), reg_rdata_out);
        rd_seen <= reg_rd_in;
    end

    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // Watchdog, far beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        err_total++;
        print_verdict();
    end

    initial begin
        {rst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = {1'b1, 26'h0};
        {alv, ovt, pin_n, rd_seen, ce} = {12'h000, 1'b0, 1'b1, 1'b0, 1'b1};
        {src, aen, swc, pen} = {16'h0004, 48'h0};
        void'($urandom(82043));
        repeat (8) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rd(8'h53, 16'h0004);
        rd(8'h54, 16'h0000);
        rd(8'h55, 16'h0000);
        rd(8'h56, 16'h0000);
        rd(8'h57, 16'h0000);
        $display("test reset values done");
        for (int a = 'h53; a <= 'h56; a++) begin
            wr(a[7:0], 16'hFFFF);
            rd(a[7:0], a == 'h53 ? 16'h7FFC : 16'h7FF8);
        end
        wr(8'h70, 16'hFFFF);
        chk_state();
        for (int a = 'h53; a <= 'h56; a++) wr(a[7:0], 16'h0000);
        $display("test reserved bits done");
        wr(8'h54, 16'($urandom) | 16'h0008);
        for (int b = 3; b <= 14; b++) begin
            wr(8'h53, 16'h0001 << b);
            alv <= 12'($urandom) | (12'h001 << (b - 3));
            chk_state();
            alv <= 12'($urandom) & ~(12'h001 << (b - 3));
            chk_state();
        end
        $display("test alarm sources done");
        alv <= 12'h000;
        ovt <= 1'b1;
        wr(8'h54, 16'h0000);
        wr(8'h53, 16'h0004);
        chk_state();
        wr(8'h53, 16'h0000);
        chk_state();
        ovt <= 1'b0;
        $display("test thermal done");
        repeat (3) begin
            wr(8'h55, 16'($urandom));
            rd(8'h55, swc);
            chk_state();
        end
        wr(8'h55, 16'h0000);
        chk_state();
        wr(8'h56, 16'($urandom));
        pin_n <= 1'b0;
        chk_state();
        wr(8'h55, 16'($urandom));
        wr(8'h54, 16'($urandom) | 16'h0008);
        wr(8'h53, 16'h4000);
        alv <= 12'h800;
        chk_state();
        wr(8'h56, 16'h0000);
        chk_state();
        pin_n <= 1'b1;
        chk_state();
        $display("test pin and combined clears done");
        // A write while the enable is low must not land anywhere.
        idle(2);
        ce <= 1'b0;
        op(1'b1, 8'h55, ~swc);
        idle(1);
        ce <= 1'b1;
        rd(8'h55, swc);
        chk_state();
        $display("test clock enable done");
        // Reset in mid-run, held two edges, must restore the source and software clear defaults.
        idle(1);
        rst_in <= 1'b1;
        idle(2);
        rst_in <= 1'b0;
        {src, aen, swc, pen} = {16'h0004, 48'h0};
        rd(8'h53, 16'h0004);
        rd(8'h55, 16'h0000);
        chk_state();
        $display("test mid-run reset done");
        idle(3);
        print_verdict();
    end
endmodule : test_dac_clear_control

bind dclr_top dclr_top_props u_props (.*);
